// [btrk_pkg.sv]
/*
 * constants, register map, config defaults and shared types of the
 * battery capacity tracker.
 * assumes a 50 MHz system clock; all users write btrk_pkg::name.
 */
package btrk_pkg;
  // clock and once-per-second refresh
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned REFRESH_MS = 1000;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * REFRESH_MS;
  // bus idle time before offset calibration, in seconds
  localparam logic [5:0] IDLE_TIME_S = 6'h14;
  // average current time constant in tenths of a second
  localparam int unsigned IIR_TAU_DS = 145;
  // filter weight in Q8 for one-second steps: 256 / (tau + 1 s)
  localparam logic [8:0] IIR_K = 9'(2560 / (IIR_TAU_DS + 10));
  localparam logic signed [47:0] SEC_PER_HOUR = 48'sh0000_0000_0E10;
  localparam logic [31:0] CAP_UNIT_DIV = 32'h0000_2710;
  // learning step limits in mAh
  localparam logic [15:0] LEARN_DROP_MAH = 16'h0100;
  localparam logic [15:0] LEARN_RISE_MAH = 16'h0200;
  // state-of-charge fractions in Q8; PCT_HUNDRED is the plain percent scale of 100
  localparam logic [7:0] PCT_LOW1 = 8'h08;
  localparam logic [7:0] PCT_Q25 = 8'h40;
  localparam logic [7:0] PCT_Q50 = 8'h80;
  localparam logic [7:0] PCT_Q75 = 8'hc0;
  localparam logic [7:0] PCT_HUNDRED = 8'h64;
  // scaling of converter readings to mV, Q16
  localparam logic [15:0] CELL_GAIN = 16'h4000;
  localparam logic [15:0] PACK_GAIN = 16'hffff;
  // converter channel codes
  localparam logic [1:0] CH_CELL = 2'h0;
  localparam logic [1:0] CH_PACK = 2'h1;
  localparam logic [1:0] CH_THERM = 2'h2;
  localparam logic [1:0] CH_INT_TEMP = 2'h3;
  // register byte offsets
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_REMAIN = 12'h008;
  localparam logic [11:0] OFS_FULL = 12'h00c;
  localparam logic [11:0] OFS_DESIGN = 12'h010;
  localparam logic [11:0] OFS_VOLT = 12'h014;
  localparam logic [11:0] OFS_CURR = 12'h018;
  localparam logic [11:0] OFS_AVG = 12'h01c;
  localparam logic [11:0] OFS_TEMP = 12'h020;
  localparam logic [11:0] OFS_PACK_RAW = 12'h024;
  localparam logic [11:0] OFS_REL_SOC = 12'h028;
  localparam logic [11:0] OFS_ABS_SOC = 12'h02c;
  localparam logic [11:0] OFS_OFFSET = 12'h030;
  localparam logic [11:0] OFS_CELL = 12'h040;
  localparam logic [11:0] OFS_CFG = 12'h080;
  // control bits
  localparam int unsigned CTRL_CAP_MODE = 0;
  localparam int unsigned CTRL_REINIT = 1;
  // config word indices, each word at OFS_CFG + 4 * index
  localparam int unsigned CFG_WORDS = 16;
  localparam logic [3:0] CFG_FILTER = 4'h0;
  localparam logic [3:0] CFG_MISC = 4'h1;
  localparam logic [3:0] CFG_PACK_CAP = 4'h2;
  localparam logic [3:0] CFG_FULL_CAP = 4'h3;
  localparam logic [3:0] CFG_NEAR_FULL = 4'h4;
  localparam logic [3:0] CFG_BAT_LOW = 4'h5;
  localparam logic [3:0] CFG_LOW0 = 4'h6;
  localparam logic [3:0] CFG_LOW1 = 4'h7;
  localparam logic [3:0] CFG_LOW2 = 4'h8;
  localparam logic [3:0] CFG_MID25 = 4'h9;
  localparam logic [3:0] CFG_MID50 = 4'ha;
  localparam logic [3:0] CFG_MID75 = 4'hb;
  localparam logic [3:0] CFG_CHG_EFF = 4'hc;
  localparam logic [3:0] CFG_SELF_DIS = 4'hd;
  localparam logic [3:0] CFG_HOT_TEMP = 4'he;
  localparam int unsigned MISC_INT_TEMP = 7;
  localparam logic [15:0] CFG_RST [CFG_WORDS] = '{
    16'h0010, 16'h0000, 16'h0fa0, 16'h0fa0, 16'h00c8, 16'h0010,
    16'h2328, 16'h2710, 16'h2904, 16'h2c88, 16'h2ee0, 16'h3138,
    16'h00f8, 16'h0004, 16'h0c1c, 16'h0000};
  // status word layout
  typedef struct packed {
    logic qualified;
    logic cal_done;
    logic cal_active;
    logic discharging;
    logic charging;
  } btrk_stat_s;
  // measurement sequencer states
  typedef enum logic [3:0] {
    M_IDLE = 4'b0001,
    M_REQ = 4'b0010,
    M_WAIT = 4'b0100,
    M_CALC = 4'b1000
  } btrk_meas_e;
endpackage

// [btrk_sync.sv]
/*
 * two-flop synchroniser for a group of asynchronous level inputs.
 * assumes inputs are slow levels; multi-bit groups are not coherent.
 */
`timescale 1ns/1ps
module btrk_sync #(
  parameter int unsigned W = 2
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] sync_r;
  logic [W-1:0] sync_nxt;

  // first stage only feeds the second
  always_comb begin
    meta_nxt = async_i;
    sync_nxt = meta_r;
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign sync_o = sync_r;
endmodule

// [btrk_top.sv]
/*
 * battery capacity tracker: coulomb counter, offset calibration,
 * measurement sequencer, capacity learning and an apb register file.
 * assumes converter strobes on clk_i, smbus lines as raw pins.
 */
// Chosen here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module btrk_top #(
  parameter int unsigned NCELL = 4,
  parameter int unsigned TICK = btrk_pkg::TICK_CYCLES,
  parameter int unsigned ACC_SHIFT = 8,
  parameter int unsigned CAL_SHIFT = 8
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic smbc_i,
  input wire logic smbd_i,
  input wire logic sense_valid_i,
  input wire logic signed [15:0] sense_count_i,
  output logic sense_short_o,
  output logic adc_start_o,
  output logic [1:0] adc_chan_o,
  output logic [1:0] afe_cell_sel_o,
  input wire logic adc_valid_i,
  input wire logic [15:0] adc_data_i,
  output logic flash_wr_o,
  output logic [15:0] flash_data_o,
  output logic [4:0] led_o
);
  logic [1:0] bus_s;
  logic [31:0] tick_cnt_r, tick_cnt_nxt;
  logic tick_r, tick_nxt;
  logic [5:0] idle_r, idle_nxt;
  logic cal_act_r, cal_act_nxt, cal_done_r, cal_done_nxt;
  logic [CAL_SHIFT:0] cal_n_r, cal_n_nxt;
  logic signed [31:0] cal_sum_r, cal_sum_nxt;
  logic signed [15:0] offset_r, offset_nxt;
  logic signed [31:0] acc_r, acc_nxt;
  logic [23:0] rm_r, rm_nxt, tally_r, tally_nxt;
  logic [15:0] fcc_r, fcc_nxt;
  logic qual_r, qual_nxt, chg_r, chg_nxt, dis_r, dis_nxt, init_r;
  logic signed [15:0] cur_r, cur_nxt, avg_r, avg_nxt;
  logic [15:0] volt_r, volt_nxt, temp_r, temp_nxt, raw_r, raw_nxt;
  logic [15:0] cell_r [NCELL];
  logic [15:0] cell_nxt [NCELL];
  logic [7:0] rel_r, rel_nxt, abs_r, abs_nxt;
  logic [4:0] led_r, led_nxt;
  logic flash_wr_r, flash_wr_nxt;
  btrk_pkg::btrk_meas_e st_r, st_nxt;
  logic [2:0] ch_r, ch_nxt;
  logic adc_start_r, adc_start_nxt;
  logic [1:0] chan_r, chan_nxt, csel_r, csel_nxt;
  logic [1:0] ctrl_r, ctrl_nxt;
  logic [15:0] cfg_r [btrk_pkg::CFG_WORDS];
  logic [15:0] cfg_nxt [btrk_pkg::CFG_WORDS];
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
  logic learn_w;
  logic [15:0] learn_val;

  // smbus pins cross into clk_i
  btrk_sync #(.W(2)) u_sync (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .async_i({smbc_i, smbd_i}),
    .sync_o(bus_s)
  );

  always_comb begin
    tick_nxt = (tick_cnt_r == 32'(TICK - 1));
    tick_cnt_nxt = tick_nxt ? 32'h0000_0000 : tick_cnt_r + 32'h0000_0001;
  end

  // offset calibration; any bus activity aborts and re-arms it
  always_comb begin
    idle_nxt = idle_r;
    cal_act_nxt = cal_act_r;
    cal_done_nxt = cal_done_r;
    cal_n_nxt = cal_n_r;
    cal_sum_nxt = cal_sum_r;
    offset_nxt = offset_r;
    if (bus_s != 2'b00) begin
      idle_nxt = 6'h00;
      cal_act_nxt = 1'b0;
      cal_done_nxt = 1'b0;
    end else if (tick_r && idle_r != btrk_pkg::IDLE_TIME_S) begin
      idle_nxt = idle_r + 6'h01;
    end
    if (bus_s == 2'b00 && idle_r == btrk_pkg::IDLE_TIME_S && !cal_act_r && !cal_done_r) begin
      cal_act_nxt = 1'b1;
      cal_n_nxt = '0;
      cal_sum_nxt = 32'sh0000_0000;
    end else if (cal_act_r && bus_s == 2'b00) begin
      if (cal_n_r[CAL_SHIFT]) begin
        offset_nxt = 16'(cal_sum_r >>> CAL_SHIFT);
        cal_act_nxt = 1'b0;
        cal_done_nxt = 1'b1;
      end else if (sense_valid_i) begin
        cal_sum_nxt = cal_sum_r + 32'(sense_count_i);
        cal_n_nxt = cal_n_r + 1'b1;
      end
    end
  end

  // per-second capacity bookkeeping, voltage correction and learning
  always_comb begin
    logic signed [16:0] corr, mag;
    logic [8:0] g;
    logic signed [26:0] prod;
    logic signed [31:0] term, dq;
    logic signed [33:0] rmx;
    logic signed [47:0] cprod;
    logic signed [16:0] diff;
    logic signed [26:0] step;
    logic [23:0] sd, pct_rm, fmax;
    logic [15:0] rm_mah, lo, hi, est;
    logic hot, near, mid_x, low2_x, any_x;
    logic [7:0] pct;
    rmx = '0;
    cprod = '0;
    diff = '0;
    step = '0;
    est = 16'h0000;
    lo = 16'h0000;
    hi = 16'h0000;
    corr = 17'(sense_count_i) - 17'(offset_r);
    mag = corr[16] ? -corr : corr;
    hot = temp_r > cfg_r[btrk_pkg::CFG_HOT_TEMP];
    rm_mah = rm_r[23:8];
    fmax = {fcc_r, 8'h00};
    near = rm_mah + cfg_r[btrk_pkg::CFG_NEAR_FULL] >= fcc_r;
    // charge efficiency derated when hot or nearly full
    g = cfg_r[btrk_pkg::CFG_CHG_EFF][8:0];
    if (hot) g = g - (g >> 3);
    if (near) g = g - (g >> 4);
    prod = 27'(corr) * $signed({18'h0_0000, g});
    term = 32'sh0000_0000;
    if (sense_valid_i && !cal_act_r
        && mag >= $signed({9'h000, cfg_r[btrk_pkg::CFG_FILTER][7:0]})) begin
      term = corr > 17'sh0_0000 ? 32'(prod >>> 8) : 32'(corr);
    end
    // integrate; transfer restarts from this cycle's count
    acc_nxt = tick_r ? term : acc_r + term;
    chg_nxt = chg_r;
    dis_nxt = dis_r;
    rm_nxt = rm_r;
    cur_nxt = cur_r;
    avg_nxt = avg_r;
    rel_nxt = rel_r;
    abs_nxt = abs_r;
    led_nxt = led_r;
    tally_nxt = tally_r;
    qual_nxt = qual_r;
    fcc_nxt = fcc_r;
    learn_w = 1'b0;
    learn_val = fcc_r;
    dq = acc_r >>> ACC_SHIFT;
    sd = {8'h00, cfg_r[btrk_pkg::CFG_SELF_DIS]} << (hot ? 1 : 0);
    if (tick_r) begin
      chg_nxt = dq > 32'sh0000_0000;
      dis_nxt = dq < 32'sh0000_0000;
      rmx = 34'(rm_r) + 34'(dq) - 34'(sd);
      if (rmx < 34'sh0_0000_0000) rm_nxt = 24'h00_0000;
      else if (rmx > 34'(fmax)) rm_nxt = fmax;
      else rm_nxt = rmx[23:0];
      cprod = 48'(dq) * btrk_pkg::SEC_PER_HOUR;
      cur_nxt = 16'(cprod >>> 8);
      diff = 17'(cur_nxt) - 17'(avg_r);
      step = 27'(diff) * $signed({18'h0_0000, btrk_pkg::IIR_K});
      avg_nxt = avg_r + 16'(step >>> 8);
      // relative charge state against learned full capacity
      rel_nxt = fcc_r == 16'h0000 ? 8'h00 :
        8'((32'(rm_mah) * 32'(btrk_pkg::PCT_HUNDRED)) / 32'(fcc_r));
      // absolute charge state against design capacity
      abs_nxt = cfg_r[btrk_pkg::CFG_PACK_CAP] == 16'h0000 ? 8'h00 :
        8'((32'(rm_mah) * 32'(btrk_pkg::PCT_HUNDRED))
        / 32'(cfg_r[btrk_pkg::CFG_PACK_CAP]));
      // bar display, one segment per fifth
      for (int i = 0; i < 5; i++) begin
        led_nxt[i] = rel_r > 8'(20 * i);
      end
      if (qual_r) begin
        tally_nxt = tally_r + (dis_nxt ? 24'(-dq) : 24'h00_0000) + sd;
      end
      if (chg_nxt) qual_nxt = 1'b0;
      else if (dis_nxt && !qual_r && near) begin
        qual_nxt = 1'b1;
        tally_nxt = {fcc_r - rm_mah, 8'h00};
      end
    end
    // voltage crossing while discharging sets charge level
    pct = 8'h00;
    mid_x = 1'b0;
    low2_x = 1'b0;
    any_x = 1'b0;
    if (st_r == btrk_pkg::M_CALC && adc_valid_i && ch_r == 3'(NCELL) && dis_r) begin
      for (int k = 11; k >= 6; k--) begin
        if (!any_x && volt_nxt < cfg_r[k] && volt_r >= cfg_r[k]) begin
          any_x = 1'b1;
          pct = k == 6 ? 8'h00 : k == 7 ? btrk_pkg::PCT_LOW1 :
            k == 8 ? cfg_r[btrk_pkg::CFG_BAT_LOW][7:0] :
            k == 9 ? btrk_pkg::PCT_Q25 : k == 10 ? btrk_pkg::PCT_Q50 : btrk_pkg::PCT_Q75;
          mid_x = k > 8;
          low2_x = k == 8;
        end
      end
    end
    pct_rm = 24'(fcc_r * pct);
    if (any_x) rm_nxt = pct_rm;
    if (mid_x) qual_nxt = 1'b0;
    // learn at the lowest-but-two level after qualified discharge
    if (low2_x && qual_r) begin
      est = tally_r[23:8] + 16'(pct_rm[23:8]);
      lo = fcc_r > btrk_pkg::LEARN_DROP_MAH ? fcc_r - btrk_pkg::LEARN_DROP_MAH : 16'h0000;
      hi = fcc_r + btrk_pkg::LEARN_RISE_MAH;
      learn_val = est < lo ? lo : est > hi ? hi : est;
      learn_w = 1'b1;
      fcc_nxt = learn_val;
      qual_nxt = 1'b0;
    end
    // load stored full capacity at init or software reinit
    if (init_r || ctrl_r[btrk_pkg::CTRL_REINIT]) begin
      fcc_nxt = cfg_r[btrk_pkg::CFG_FULL_CAP];
      rm_nxt = rm_r > {cfg_r[btrk_pkg::CFG_FULL_CAP], 8'h00} ?
        {cfg_r[btrk_pkg::CFG_FULL_CAP], 8'h00} : rm_r;
      qual_nxt = 1'b0;
    end
    flash_wr_nxt = learn_w;
  end

  // measurement sequencer: cells, pack, temperature each second
  always_comb begin
    st_nxt = st_r;
    ch_nxt = ch_r;
    adc_start_nxt = 1'b0;
    chan_nxt = chan_r;
    csel_nxt = csel_r;
    volt_nxt = volt_r;
    temp_nxt = temp_r;
    raw_nxt = raw_r;
    for (int i = 0; i < NCELL; i++) cell_nxt[i] = cell_r[i];
    case (st_r)
      btrk_pkg::M_IDLE: begin
        if (tick_r) begin
          ch_nxt = 3'h0;
          st_nxt = btrk_pkg::M_REQ;
        end
      end
      btrk_pkg::M_REQ: begin
        // route the cell on the front end in the same cycle as the start pulse
        csel_nxt = 2'(ch_r);
        chan_nxt = ch_r < 3'(NCELL) ? btrk_pkg::CH_CELL :
          ch_r == 3'(NCELL) ? btrk_pkg::CH_PACK :
          cfg_r[btrk_pkg::CFG_MISC][btrk_pkg::MISC_INT_TEMP] ?
          btrk_pkg::CH_INT_TEMP : btrk_pkg::CH_THERM;
        adc_start_nxt = 1'b1;
        st_nxt = btrk_pkg::M_CALC;
      end
      btrk_pkg::M_CALC: begin
        if (adc_valid_i) begin
          if (ch_r < 3'(NCELL)) begin
            cell_nxt[ch_r[1:0]] = 16'((32'(adc_data_i) * 32'(btrk_pkg::CELL_GAIN)) >> 16);
          end else if (ch_r == 3'(NCELL)) begin
            // raw pack reading kept alongside scaled value
            raw_nxt = adc_data_i;
            volt_nxt = 16'((32'(adc_data_i) * 32'(btrk_pkg::PACK_GAIN)) >> 16);
          end else begin
            temp_nxt = adc_data_i;
          end
          ch_nxt = ch_r + 3'h1;
          st_nxt = ch_r == 3'(NCELL + 1) ? btrk_pkg::M_IDLE : btrk_pkg::M_REQ;
        end
      end
      default: st_nxt = btrk_pkg::M_IDLE;
    endcase
  end

  // apb slave, one wait-free access phase; unmapped reads error
  always_comb begin
    logic [15:0] idx;
    logic [3:0] ci;
    logic hit;
    btrk_pkg::btrk_stat_s stat;
    ctrl_nxt = ctrl_r & ~(2'h1 << btrk_pkg::CTRL_REINIT);
    for (int i = 0; i < btrk_pkg::CFG_WORDS; i++) cfg_nxt[i] = cfg_r[i];
    pready_nxt = psel_i && !penable_i;
    prdata_nxt = prdata_r;
    pslverr_nxt = 1'b0;
    stat = '{qual_r, cal_done_r, cal_act_r, dis_r, chg_r};
    idx = 16'(paddr_i[11:2]);
    ci = paddr_i[5:2];
    hit = 1'b1;
    if (psel_i && !penable_i) begin
      prdata_nxt = 32'h0000_0000;
      // tally has no address; capacities in chosen unit
      case (paddr_i)
        btrk_pkg::OFS_CTRL: prdata_nxt = 32'(ctrl_r);
        btrk_pkg::OFS_STATUS: prdata_nxt = 32'(stat);
        btrk_pkg::OFS_REMAIN: prdata_nxt = 32'(cap_view(rm_r[23:8]));
        btrk_pkg::OFS_FULL: prdata_nxt = 32'(cap_view(fcc_r));
        btrk_pkg::OFS_DESIGN: prdata_nxt = 32'(cap_view(cfg_r[btrk_pkg::CFG_PACK_CAP]));
        btrk_pkg::OFS_VOLT: prdata_nxt = 32'(volt_r);
        btrk_pkg::OFS_CURR: prdata_nxt = 32'($unsigned(cur_r));
        btrk_pkg::OFS_AVG: prdata_nxt = 32'($unsigned(avg_r));
        btrk_pkg::OFS_TEMP: prdata_nxt = 32'(temp_r);
        btrk_pkg::OFS_PACK_RAW: prdata_nxt = 32'(raw_r);
        btrk_pkg::OFS_REL_SOC: prdata_nxt = 32'(rel_r);
        btrk_pkg::OFS_ABS_SOC: prdata_nxt = 32'(abs_r);
        btrk_pkg::OFS_OFFSET: prdata_nxt = 32'($unsigned(offset_r));
        default: begin
          if (paddr_i[1:0] == 2'b00 && paddr_i >= btrk_pkg::OFS_CELL
              && paddr_i < btrk_pkg::OFS_CELL + 12'(4 * NCELL)) begin
            prdata_nxt = 32'(cell_r[2'(idx - 16'(btrk_pkg::OFS_CELL >> 2))]);
          end else if (paddr_i[11:6] == btrk_pkg::OFS_CFG[11:6] && paddr_i[1:0] == 2'b00) begin
            prdata_nxt = 32'(cfg_r[ci]);
          end else begin
            hit = 1'b0;
          end
        end
      endcase
      pslverr_nxt = !hit || (pwrite_i && paddr_i != btrk_pkg::OFS_CTRL
        && !(paddr_i[11:6] == btrk_pkg::OFS_CFG[11:6] && paddr_i[1:0] == 2'b00));
    end
    if (psel_i && penable_i && pready_r && pwrite_i && !pslverr_r) begin
      if (paddr_i == btrk_pkg::OFS_CTRL) ctrl_nxt = pwdata_i[1:0];
      else cfg_nxt[ci] = pwdata_i[15:0];
    end
    // learned value in mAh overrides a same-cycle write
    if (learn_w) cfg_nxt[btrk_pkg::CFG_FULL_CAP] = learn_val;
  end

  // 10 mWh view: mAh times pack mV over ten thousand
  function automatic logic [15:0] cap_view(input logic [15:0] mah);
    logic [31:0] p;
    p = (32'(mah) * 32'(volt_r)) / btrk_pkg::CAP_UNIT_DIV;
    return ctrl_r[btrk_pkg::CTRL_CAP_MODE] ? p[15:0] : mah;
  endfunction

  // all state registers; config words reset to their table
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tick_cnt_r <= 32'h0000_0000;
      tick_r <= 1'b0;
      idle_r <= 6'h00;
      cal_act_r <= 1'b0;
      cal_done_r <= 1'b0;
      cal_n_r <= '0;
      cal_sum_r <= 32'sh0000_0000;
      offset_r <= 16'sh0000;
      acc_r <= 32'sh0000_0000;
      rm_r <= 24'h00_0000;
      tally_r <= 24'h00_0000;
      fcc_r <= 16'h0000;
      qual_r <= 1'b0;
      chg_r <= 1'b0;
      dis_r <= 1'b0;
      init_r <= 1'b1;
      cur_r <= 16'sh0000;
      avg_r <= 16'sh0000;
      volt_r <= 16'h0000;
      temp_r <= 16'h0000;
      raw_r <= 16'h0000;
      for (int i = 0; i < NCELL; i++) cell_r[i] <= 16'h0000;
      rel_r <= 8'h00;
      abs_r <= 8'h00;
      led_r <= 5'h00;
      flash_wr_r <= 1'b0;
      st_r <= btrk_pkg::M_IDLE;
      ch_r <= 3'h0;
      adc_start_r <= 1'b0;
      chan_r <= btrk_pkg::CH_CELL;
      csel_r <= 2'h0;
      ctrl_r <= 2'h0;
      for (int i = 0; i < btrk_pkg::CFG_WORDS; i++) cfg_r[i] <= btrk_pkg::CFG_RST[i];
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      tick_cnt_r <= tick_cnt_nxt;
      tick_r <= tick_nxt;
      idle_r <= idle_nxt;
      cal_act_r <= cal_act_nxt;
      cal_done_r <= cal_done_nxt;
      cal_n_r <= cal_n_nxt;
      cal_sum_r <= cal_sum_nxt;
      offset_r <= offset_nxt;
      acc_r <= acc_nxt;
      rm_r <= rm_nxt;
      tally_r <= tally_nxt;
      fcc_r <= fcc_nxt;
      qual_r <= qual_nxt;
      chg_r <= chg_nxt;
      dis_r <= dis_nxt;
      init_r <= 1'b0;
      cur_r <= cur_nxt;
      avg_r <= avg_nxt;
      volt_r <= volt_nxt;
      temp_r <= temp_nxt;
      raw_r <= raw_nxt;
      for (int i = 0; i < NCELL; i++) cell_r[i] <= cell_nxt[i];
      rel_r <= rel_nxt;
      abs_r <= abs_nxt;
      led_r <= led_nxt;
      flash_wr_r <= flash_wr_nxt;
      st_r <= st_nxt;
      ch_r <= ch_nxt;
      adc_start_r <= adc_start_nxt;
      chan_r <= chan_nxt;
      csel_r <= csel_nxt;
      ctrl_r <= ctrl_nxt;
      for (int i = 0; i < btrk_pkg::CFG_WORDS; i++) cfg_r[i] <= cfg_nxt[i];
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // outputs straight from flops
  assign prdata_o = prdata_r;
  assign pready_o = pready_r;
  assign pslverr_o = pslverr_r;
  assign sense_short_o = cal_act_r;
  assign adc_start_o = adc_start_r;
  assign adc_chan_o = chan_r;
  assign afe_cell_sel_o = csel_r;
  assign flash_wr_o = flash_wr_r;
  assign flash_data_o = fcc_r;
  assign led_o = led_r;
endmodule

// [btrk_checker.sv]
/* port checker for btrk_top.
   assumes a bind from the bench top file. */
`timescale 1ns/1ps
module btrk_checker (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic smbc_i,
  input wire logic smbd_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic sense_short_o,
  input wire logic adc_start_o,
  input wire logic [1:0] adc_chan_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);
  AST_APB_ANSWER:
    assert property (psel_i && !penable_i |=> pready_o) else $error("late answer");
  AST_APB_PULSE:
    assert property (pready_o |=> !pready_o) else $error("ready too long");
  AST_APB_QUIET:
    assert property (!psel_i |=> !pready_o) else $error("ready unasked");
  AST_ERR_WITH_READY:
    assert property (pslverr_o |-> pready_o) else $error("stray error");
  AST_ADC_PULSE:
    assert property (adc_start_o |=> !adc_start_o) else $error("start too long");
  AST_ADC_HOLD:
    assert property (adc_start_o |=> $stable(adc_chan_o)) else $error("channel moved");
  AST_CAL_ABORT:
    assert property (sense_short_o && smbc_i |-> ##[1:4] !sense_short_o) else $error("no abort");
  AST_CAL_IDLE:
    assert property ($rose(sense_short_o) |-> !$past(smbc_i, 4) && !$past(smbd_i, 4))
      else $error("short while busy");
  cover property ($rose(sense_short_o));
  cover property (pslverr_o);
  cover property (adc_start_o && adc_chan_o == 2'h3);
endmodule

// [btrk_afe_model.sv]
/* front end and sense converter model.
   assumes one clock; flow_i set by the bench. */
`timescale 1ns/1ps
module btrk_afe_model (
  input wire logic clk_i,
  input wire logic adc_start_i,
  input wire logic [1:0] adc_chan_i,
  input wire logic [1:0] cell_sel_i,
  input wire logic signed [15:0] flow_i,
  output logic adc_valid_o,
  output logic [15:0] adc_data_o,
  output logic sense_valid_o,
  output logic signed [15:0] sense_count_o
);
  logic [3:0] wait_q;
  logic [1:0] cnt_q;
  logic [15:0] val;
  initial {adc_valid_o, adc_data_o, sense_valid_o, sense_count_o, wait_q, cnt_q} = '0;
  // routed cell shows in cell readings only; other channels ignore the mux
  always_comb val = 16'h3800 ^ {2'h0, adc_chan_i ^ 2'h1, 8'h00,
    (adc_chan_i == 2'h0 ? cell_sel_i : 2'h0), 2'h0};
  // idle data flips so a stale value never passes
  always @(posedge clk_i) begin
    cnt_q <= cnt_q + 2'h1;
    sense_valid_o <= cnt_q == 2'h3;
    sense_count_o <= cnt_q == 2'h3 ? flow_i : ~sense_count_o;
    wait_q <= adc_start_i ? 4'h3 : wait_q - 4'(wait_q != 4'h0);
    adc_valid_o <= wait_q == 4'h1;
    adc_data_o <= wait_q == 4'h1 ? val : ~adc_data_o;
  end
endmodule

// [btrk_top_bench.sv]
/* self-checking bench for btrk_top.
   assumes a 200-cycle second; bus lines held high (busy) until t_cal drives both low. */
`timescale 1ns/1ps
module btrk_top_bench;
  localparam int TK = 200;
  logic clk_i = 1'b0, rst_b_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic smbc_i = 1'b1, smbd_i = 1'b1, err, sense_valid_i, adc_valid_i;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0000_0000, rd, prdata_o;
  logic signed [15:0] flow = 16'sh0000, sense_count_i;
  logic pready_o, pslverr_o, sense_short_o, adc_start_o, flash_wr_o;
  logic [1:0] adc_chan_o, afe_cell_sel_o;
  logic [15:0] adc_data_i, flash_data_o;
  logic [4:0] led_o;
  int miscompares = 0, samples_checked = 0;
  always #10 clk_i = ~clk_i;
  btrk_top #(.TICK(TK), .CAL_SHIFT(2)) uut (.*);
  btrk_afe_model am (.clk_i, .adc_start_i(adc_start_o), .adc_chan_i(adc_chan_o),
    .cell_sel_i(afe_cell_sel_o), .flow_i(flow), .adc_valid_o(adc_valid_i),
    .adc_data_o(adc_data_i), .sense_valid_o(sense_valid_i), .sense_count_o(sense_count_i));
  task automatic report_and_stop();
    $display("mismatches %0d of %0d", miscompares, samples_checked);
    if (miscompares == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // one apb transfer, held until ready is sampled
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {2'b10, w, a, d};
    @(posedge clk_i);
    penable_i <= 1'b1;
    for (n = 0; n < 9 && pready_o !== 1'b1; n++) @(posedge clk_i);
    if (n == 9) chk(n, 0);
    if (n == 9) report_and_stop();
    {rd, err} = {prdata_o, pslverr_o};
    {psel_i, penable_i} <= 2'b00;
    @(posedge clk_i);
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    chk(rd, e);
  endtask
  task automatic t_init();
    rdchk(12'h00c, 32'h0000_0fa0);
    rdchk(12'h010, 32'h0000_0fa0);
    rdchk(12'h034, 32'h0000_0000);
    chk(err, 1);
    bus(1'b1, 12'h008, 32'h0000_1234);
    chk(err, 1);
  endtask
  task automatic t_count();
    bus(1'b1, 12'h0b4, 32'h0000_0000);
    bus(1'b1, 12'h08c, 32'h0000_0002);
    bus(1'b1, 12'h000, 32'h0000_0002);
    rdchk(12'h00c, 32'h0000_0002);
    chk(flash_data_o, 32'h0000_0002);
    flow <= 16'sh7fff;
    repeat (3 * TK) @(posedge clk_i);
    rdchk(12'h008, 32'h0000_0002);
    bus(1'b0, 12'h004, 32'h0000_0000);
    chk(rd & 32'h0000_0003, 32'h0000_0001);
    flow <= -16'sh0008;
    repeat (3 * TK) @(posedge clk_i);
    rdchk(12'h008, 32'h0000_0002);
    rdchk(12'h028, 32'h0000_0064);
    chk(led_o, 32'h0000_001f);
    flow <= -16'sh7fff;
    repeat (3 * TK) @(posedge clk_i);
    rdchk(12'h008, 32'h0000_0000);
    flow <= 16'sh0000;
  endtask
  task automatic t_meas();
    for (int i = 0; i < 4; i++) rdchk(12'h040 + 12'(4 * i), 32'h0000_0a00 + i);
    rdchk(12'h024, 32'h0000_3800);
    rdchk(12'h014, 32'h0000_37ff);
    rdchk(12'h020, 32'h0000_0800);
    bus(1'b1, 12'h0b8, 32'h0000_1666);
    bus(1'b1, 12'h084, 32'h0000_0080);
    repeat (2 * TK) @(posedge clk_i);
    rdchk(12'h020, 32'h0000_1800);
    bus(1'b1, 12'h000, 32'h0000_0001);
    rdchk(12'h010, 32'h0000_1666);
  endtask
  task automatic t_cal();
    int n;
    {smbc_i, smbd_i} <= 2'b00;
    for (n = 0; n < 30 * TK && sense_short_o !== 1'b1; n++) @(posedge clk_i);
    chk(n > 19 * TK, 1);
    chk(sense_short_o, 1);
    smbc_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    chk(sense_short_o, 0);
  endtask
  initial begin
    repeat (4) @(posedge clk_i);
    rst_b_i <= 1'b1;
    @(posedge clk_i);
    t_init();
    t_count();
    t_meas();
    t_cal();
    report_and_stop();
  end
endmodule
bind btrk_top btrk_checker chk_u (.*);
